// file: dtbl_pkg.sv
// Constants, types and helper functions for the drive terminal and brake logic
package dtbl_pkg;

  // Clock rate and the times derived from it
  localparam int unsigned CLK_HZ        = 200_000_000;           // System clock rate
  localparam int unsigned TICK_MS       = 100;                   // Brake timer unit, 0.1 s
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS; // Cycles per 0.1 s
  localparam int unsigned RST_HOLD_MS   = 10;                    // Least fault-reset hold
  localparam int unsigned RST_HOLD_CYC  = CLK_HZ / 1000 * RST_HOLD_MS; // Hold in cycles

  // Register word offsets on the parameter map
  localparam logic [15:0] ADDR_IN1_FN    = 16'h0101; // Input one function select
  localparam logic [15:0] ADDR_IN2_FN    = 16'h0102; // Input two function select
  localparam logic [15:0] ADDR_IN3_FN    = 16'h0103; // Input three function select
  localparam logic [15:0] ADDR_IN4_FN    = 16'h0104; // Input four function select
  localparam logic [15:0] ADDR_IN5_FN    = 16'h0105; // Input five function select
  localparam logic [15:0] ADDR_RLY_A_FN  = 16'h0106; // Relay output A function
  localparam logic [15:0] ADDR_RLY_B_FN  = 16'h0107; // Changeover relay function
  localparam logic [15:0] ADDR_REL_CUR   = 16'h010E; // Brake release current
  localparam logic [15:0] ADDR_REL_FREQ  = 16'h010F; // Brake release frequency
  localparam logic [15:0] ADDR_REL_TIMER = 16'h0110; // Brake release timer
  localparam logic [15:0] ADDR_ENG_FREQ  = 16'h0111; // Brake engage frequency
  localparam logic [15:0] ADDR_ENG_TIMER = 16'h0112; // Brake engage timer
  localparam logic [15:0] ADDR_IN2_FN2   = 16'h0117; // Input two second function
  localparam logic [15:0] ADDR_IN3_FN2   = 16'h0118; // Input three second function
  localparam logic [15:0] ADDR_STATUS    = 16'h0130; // Read-only block status

  // Function codes of inputs and outputs
  localparam logic [15:0] FN_SS1     = 16'h0000; // Frequency select bit 0
  localparam logic [15:0] FN_SS2     = 16'h0001; // Frequency select bit 1
  localparam logic [15:0] FN_RST     = 16'h0008; // Fault reset
  localparam logic [15:0] FN_SA1     = 16'h0032; // Ramp select bit 0
  localparam logic [15:0] FN_SA2     = 16'h0033; // Ramp select bit 1
  localparam logic [15:0] FN_FWD     = 16'h0062; // Forward run
  localparam logic [15:0] FN_REV     = 16'h0063; // Backward run
  localparam logic [15:0] FN_BRAKE_CONTROL_SIGNAL    = 16'h0039; // Brake control signal
  localparam logic [15:0] FN_ALM     = 16'h0063; // Fault output
  localparam logic [15:0] FN_NEG_OFS = 16'h03E8; // Offset of active-off codes

  // Reset values
  localparam logic [15:0] RST_IN1_FN    = FN_FWD;
  localparam logic [15:0] RST_IN2_FN    = FN_SS1;
  localparam logic [15:0] RST_IN3_FN    = FN_SS2;
  localparam logic [15:0] RST_IN4_FN    = FN_REV;
  localparam logic [15:0] RST_IN5_FN    = FN_RST;
  localparam logic [15:0] RST_IN2_FN2   = FN_SA1;
  localparam logic [15:0] RST_IN3_FN2   = FN_SA2;
  localparam logic [15:0] RST_RLY_A_FN  = 16'h0039;
  localparam logic [15:0] RST_RLY_B_FN  = 16'h0063;
  localparam logic [15:0] RST_REL_CUR   = 16'h0064;
  localparam logic [15:0] RST_REL_FREQ  = 16'h000A;
  localparam logic [15:0] RST_REL_TIMER = 16'h000A;
  localparam logic [15:0] RST_ENG_FREQ  = 16'h000A;
  localparam logic [15:0] RST_ENG_TIMER = 16'h000A;

  // Upper limits of brake settings
  localparam logic [15:0] MAX_FREQ  = 16'h00FA; // 25.0 Hz in 0.1 Hz
  localparam logic [15:0] MAX_TIMER = 16'h0032; // 5.0 s in 0.1 s
  localparam logic [15:0] MAX_CUR   = 16'h00C8; // 200 percent

  // Status register bit positions
  localparam int unsigned ST_BRAKE_REL = 0;
  localparam int unsigned ST_FAULT     = 1;
  localparam int unsigned ST_STO_TRIP  = 2;
  localparam int unsigned ST_FWD       = 3;
  localparam int unsigned ST_REV       = 4;
  localparam int unsigned ST_GATE_EN   = 5;

  // Brake sequencer states
  typedef enum logic {
    BRK_ENGAGED,
    BRK_RELEASED
  } dtbl_brake_t;

  // Input pin matches a function, in either polarity
  function automatic logic dtbl_fn_hit(input logic [15:0] code,
                                       input logic [15:0] base,
                                       input logic        pin);
    dtbl_fn_hit = ((code == base) && pin) ||
                  ((code == 16'(base + FN_NEG_OFS)) && !pin);
  endfunction

  // Relay drive from its function code
  function automatic logic dtbl_relay(input logic [15:0] code,
                                      input logic        brake,
                                      input logic        fault);
    logic r;
    r = 1'b0;
    if (code == FN_BRAKE_CONTROL_SIGNAL) r = brake;
    else if (code == 16'(FN_BRAKE_CONTROL_SIGNAL + FN_NEG_OFS)) r = !brake;
    else if (code == FN_ALM) r = fault;
    else if (code == 16'(FN_ALM + FN_NEG_OFS)) r = !fault;
    dtbl_relay = r;
  endfunction

  // Limit a written value to its range
  function automatic logic [15:0] dtbl_clamp(input logic [15:0] v,
                                             input logic [15:0] mx);
    dtbl_clamp = (v > mx) ? mx : v;
  endfunction

endpackage : dtbl_pkg

// file: dtbl_hold_timer.sv
// Hold timer counting uninterrupted 0.1 s intervals of a condition
module dtbl_hold_timer
  import dtbl_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYC // Cycles per 0.1 s
)(
  input  wire logic        i_clk_sys, // System clock
  input  wire logic        i_rst_b,   // Synchronous reset, active low
  input  wire logic        i_cond,    // Qualifying condition
  input  wire logic [15:0] i_limit,   // Hold time in 0.1 s
  output logic             o_done     // Condition held long enough
);

  // Timer state
  typedef struct packed {
    logic [31:0] pre;   // Cycles within current tick
    logic [15:0] ticks; // Whole ticks elapsed
    logic        done;  // Expired flag
  } dtbl_tmr_t;

  dtbl_tmr_t st_q; // Registered state
  dtbl_tmr_t st_d; // Next state

  // Count while held, restart when it drops
  always_comb
  begin
    st_d = st_q;
    if (!i_cond)
    begin
      st_d.pre   = 32'h0000_0000;
      st_d.ticks = 16'h0000;
    end
    else if (st_q.ticks < i_limit)
    begin
      if (st_q.pre >= 32'(TICK - 1))
      begin
        st_d.pre   = 32'h0000_0000;
        st_d.ticks = 16'(st_q.ticks + 16'h0001);
      end
      else
      begin
        st_d.pre = 32'(st_q.pre + 32'h0000_0001);
      end
    end
    st_d.done = i_cond && (st_d.ticks >= i_limit);
  end

  // State register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_done = st_q.done;

endmodule // dtbl_hold_timer

// file: dtbl_terminal.sv
// Relay outputs, brake sequencer, torque cutoff and digital input decoding
//
// Summary of operation
// - Relay A and changeover relay each have own function and polarity
// - Codes 57/1057 route brake signal
// - Codes 99/1099 route fault indication
// - Fault energizes changeover relay, negative de-energizes
// - Stop plus low frequency held engages brake
// - Run plus current or frequency held releases
// - Brake settings clamped to documented ranges
// - Either cutoff channel open kills gates
// - No start until channels restored and reset
// - Default inputs: fwd, selects, rev, reset
// - One direction runs; none or both ramp down
// - Selects pick target and ramp pair
// - Ramp down uses selected deceleration time
// - Frequency bits choose base or presets
// - Reset clears fault; hold it 10 ms
module dtbl_terminal
  import dtbl_pkg::*;
#(
  parameter int unsigned TICK     = TICK_CYC,    // Cycles per 0.1 s
  parameter int unsigned RST_HOLD = RST_HOLD_CYC // Fault reset hold cycles
)(
  input  wire logic        i_clk_sys,                // System clock
  input  wire logic        i_rst_b,                  // Synchronous reset, active low
  input  wire logic        i_reg_wr,                 // Register write strobe
  input  wire logic        i_reg_rd,                 // Register read strobe
  input  wire logic [15:0] i_reg_addr,               // Register word address
  input  wire logic [15:0] i_reg_wdata,              // Register write data
  output logic [15:0]      o_reg_rdata,              // Register read data
  output logic             o_reg_rvalid,             // Read data valid pulse
  input  wire logic        i_input_one,              // Digital input one
  input  wire logic        i_input_two,              // Digital input two
  input  wire logic        i_input_three,            // Digital input three
  input  wire logic        i_input_four,             // Digital input four
  input  wire logic        i_input_five,             // Digital input five
  input  wire logic        i_safe_torque_cutoff_a,   // Cutoff channel A closed
  input  wire logic        i_safe_torque_cutoff_b,   // Cutoff channel B closed
  input  wire logic        i_fault_present,          // Any other drive fault
  input  wire logic [15:0] i_out_freq,               // Output frequency, 0.1 Hz
  input  wire logic [15:0] i_out_current,            // Output current, percent
  output logic             o_relay_out_a,            // Relay A energize
  output logic             o_relay_out_b_changeover, // Changeover relay energize
  output logic             o_brake_relay_one,        // Brake relay one
  output logic             o_brake_relay_two,        // Brake relay two
  output logic             o_fault_output,           // Fault latched
  output logic             o_gate_enable,            // Output gate drive allowed
  output logic             o_sto_tripped,            // Cutoff trip latched
  output logic             o_forward_run,            // Run forward
  output logic             o_backward_run,           // Run backward
  output logic             o_target_zero,            // Ramp to 0 Hz
  output logic [1:0]       o_freq_sel,               // 0 base, 1..3 preset
  output logic [1:0]       o_ramp_sel                // 0 base pair, 1..3 preset pair
);

  // All state of the block
  typedef struct packed {
    logic [4:0][15:0] in_fn;     // First function of each input
    logic [1:0][15:0] in_fn2;    // Second function of inputs two and three
    logic [15:0]      rly_a_fn;  // Relay A function code
    logic [15:0]      rly_b_fn;  // Changeover relay function code
    logic [15:0]      rel_cur;   // Release current threshold
    logic [15:0]      rel_freq;  // Release frequency threshold
    logic [15:0]      rel_timer; // Release hold time
    logic [15:0]      eng_freq;  // Engage frequency threshold
    logic [15:0]      eng_timer; // Engage hold time
    dtbl_brake_t      brake;     // Brake sequencer state
    logic             fault;     // Fault latch
    logic             sto_trip;  // Cutoff trip latch
    logic [31:0]      rst_cnt;   // Fault reset hold count
    logic             forward_run;       // Forward run
    logic             backward_run;       // Backward run
    logic [1:0]       fsel;      // Frequency select
    logic [1:0]       rsel;      // Ramp select
    logic             rly_a;     // Relay A drive
    logic             rly_b;     // Changeover relay drive
    logic [15:0]      rdata;     // Read data
    logic             rvalid;    // Read answer pulse
  } dtbl_state_t;

  dtbl_state_t st_q; // Registered state
  dtbl_state_t st_d; // Next state

  logic [4:0] pins;      // Input pins as a vector
  logic       chans_ok;  // Both cutoff channels closed
  logic       run;       // Registered run command
  logic       rel_cond;  // Release condition
  logic       eng_cond;  // Engage condition
  logic       rel_done;  // Release condition held
  logic       eng_done;  // Engage condition held
  logic       brake_sig; // Brake release signal
  logic [15:0] status;   // Status word

  assign pins      = {i_input_five, i_input_four, i_input_three, i_input_two, i_input_one};
  assign chans_ok  = i_safe_torque_cutoff_a && i_safe_torque_cutoff_b;
  assign run       = st_q.forward_run || st_q.backward_run;
  assign brake_sig = (st_q.brake == BRK_RELEASED);

  // Brake conditions from thresholds
  always_comb
  begin
    rel_cond = run && ((i_out_current > st_q.rel_cur) || (i_out_freq > st_q.rel_freq));
    eng_cond = !run && (i_out_freq < st_q.eng_freq);
  end

  // Release hold timer
  dtbl_hold_timer #(
    .TICK (TICK)
  ) u_rel_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_cond    (rel_cond),
    .i_limit   (st_q.rel_timer),
    .o_done    (rel_done)
  );

  // Engage hold timer
  dtbl_hold_timer #(
    .TICK (TICK)
  ) u_eng_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_cond    (eng_cond),
    .i_limit   (st_q.eng_timer),
    .o_done    (eng_done)
  );

  // Status word for reads
  always_comb
  begin
    status               = 16'h0000;
    status[ST_BRAKE_REL] = brake_sig;
    status[ST_FAULT]     = st_q.fault;
    status[ST_STO_TRIP]  = st_q.sto_trip;
    status[ST_FWD]       = st_q.forward_run;
    status[ST_REV]       = st_q.backward_run;
    status[ST_GATE_EN]   = o_gate_enable;
  end

  // Next-state logic
  always_comb
  begin
    logic f_ss1;   // Frequency bit 0 seen
    logic f_ss2;   // Frequency bit 1 seen
    logic f_sa1;   // Ramp bit 0 seen
    logic f_sa2;   // Ramp bit 1 seen
    logic f_fwd;   // Forward seen
    logic f_rev;   // Backward seen
    logic f_rst;   // Fault reset seen
    logic rst_ok;  // Fault reset held long enough

    f_ss1  = 1'b0;
    f_ss2  = 1'b0;
    f_sa1  = 1'b0;
    f_sa2  = 1'b0;
    f_fwd  = 1'b0;
    f_rev  = 1'b0;
    f_rst  = 1'b0;
    rst_ok = 1'b0;
    st_d   = st_q;

    for (int i = 0; i < 5; i++)
    begin
      f_ss1 = f_ss1 || dtbl_fn_hit(st_q.in_fn[i], FN_SS1, pins[i]);
      f_ss2 = f_ss2 || dtbl_fn_hit(st_q.in_fn[i], FN_SS2, pins[i]);
      f_sa1 = f_sa1 || dtbl_fn_hit(st_q.in_fn[i], FN_SA1, pins[i]);
      f_sa2 = f_sa2 || dtbl_fn_hit(st_q.in_fn[i], FN_SA2, pins[i]);
      f_fwd = f_fwd || dtbl_fn_hit(st_q.in_fn[i], FN_FWD, pins[i]);
      f_rev = f_rev || dtbl_fn_hit(st_q.in_fn[i], FN_REV, pins[i]);
      f_rst = f_rst || dtbl_fn_hit(st_q.in_fn[i], FN_RST, pins[i]);
    end

    // Second functions of inputs two and three
    for (int j = 0; j < 2; j++)
    begin
      f_sa1 = f_sa1 || dtbl_fn_hit(st_q.in_fn2[j], FN_SA1, pins[j + 1]);
      f_sa2 = f_sa2 || dtbl_fn_hit(st_q.in_fn2[j], FN_SA2, pins[j + 1]);
    end

    // reset must stay on its hold time
    if (!f_rst)
      st_d.rst_cnt = 32'h0000_0000;
    else if (st_q.rst_cnt < 32'(RST_HOLD))
      st_d.rst_cnt = 32'(st_q.rst_cnt + 32'h0000_0001);
    rst_ok = (st_q.rst_cnt >= 32'(RST_HOLD));

    // trip clears only with channels closed and reset
    st_d.sto_trip = !chans_ok || (st_q.sto_trip && !rst_ok);

    // fault latch, new fault wins over reset
    st_d.fault = i_fault_present || !chans_ok || st_q.sto_trip ||
                 (st_q.fault && !rst_ok);

    st_d.forward_run = f_fwd && !f_rev && chans_ok && !st_q.sto_trip;
    st_d.backward_run = f_rev && !f_fwd && chans_ok && !st_q.sto_trip;

    st_d.fsel = {f_ss2, f_ss1};
    st_d.rsel = {f_sa2, f_sa1};

    // Brake sequencer
    case (st_q.brake)
      BRK_ENGAGED:
      begin
        if (run && rel_done)
          st_d.brake = BRK_RELEASED;
      end
      BRK_RELEASED:
      begin
        if (!run && eng_done)
          st_d.brake = BRK_ENGAGED;
      end
      default:
      begin
        st_d.brake = BRK_ENGAGED;
      end
    endcase

    // each relay from its own code
    st_d.rly_a = dtbl_relay(st_q.rly_a_fn, brake_sig, st_q.fault);
    st_d.rly_b = dtbl_relay(st_q.rly_b_fn, brake_sig, st_q.fault);

    // Register writes
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        ADDR_IN1_FN:    st_d.in_fn[0]  = i_reg_wdata;
        ADDR_IN2_FN:    st_d.in_fn[1]  = i_reg_wdata;
        ADDR_IN3_FN:    st_d.in_fn[2]  = i_reg_wdata;
        ADDR_IN4_FN:    st_d.in_fn[3]  = i_reg_wdata;
        ADDR_IN5_FN:    st_d.in_fn[4]  = i_reg_wdata;
        ADDR_IN2_FN2:   st_d.in_fn2[0] = i_reg_wdata;
        ADDR_IN3_FN2:   st_d.in_fn2[1] = i_reg_wdata;
        ADDR_RLY_A_FN:  st_d.rly_a_fn  = i_reg_wdata;
        ADDR_RLY_B_FN:  st_d.rly_b_fn  = i_reg_wdata;
        ADDR_REL_CUR:   st_d.rel_cur   = dtbl_clamp(i_reg_wdata, MAX_CUR);
        ADDR_REL_FREQ:  st_d.rel_freq  = dtbl_clamp(i_reg_wdata, MAX_FREQ);
        ADDR_REL_TIMER: st_d.rel_timer = dtbl_clamp(i_reg_wdata, MAX_TIMER);
        ADDR_ENG_FREQ:  st_d.eng_freq  = dtbl_clamp(i_reg_wdata, MAX_FREQ);
        ADDR_ENG_TIMER: st_d.eng_timer = dtbl_clamp(i_reg_wdata, MAX_TIMER);
        // Status and unmapped words ignore writes
        default:        ;
      endcase
    end

    // Register reads, unmapped words read zero
    st_d.rvalid = i_reg_rd;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        ADDR_IN1_FN:    st_d.rdata = st_q.in_fn[0];
        ADDR_IN2_FN:    st_d.rdata = st_q.in_fn[1];
        ADDR_IN3_FN:    st_d.rdata = st_q.in_fn[2];
        ADDR_IN4_FN:    st_d.rdata = st_q.in_fn[3];
        ADDR_IN5_FN:    st_d.rdata = st_q.in_fn[4];
        ADDR_IN2_FN2:   st_d.rdata = st_q.in_fn2[0];
        ADDR_IN3_FN2:   st_d.rdata = st_q.in_fn2[1];
        ADDR_RLY_A_FN:  st_d.rdata = st_q.rly_a_fn;
        ADDR_RLY_B_FN:  st_d.rdata = st_q.rly_b_fn;
        ADDR_REL_CUR:   st_d.rdata = st_q.rel_cur;
        ADDR_REL_FREQ:  st_d.rdata = st_q.rel_freq;
        ADDR_REL_TIMER: st_d.rdata = st_q.rel_timer;
        ADDR_ENG_FREQ:  st_d.rdata = st_q.eng_freq;
        ADDR_ENG_TIMER: st_d.rdata = st_q.eng_timer;
        ADDR_STATUS:    st_d.rdata = status;
        default:        st_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register with reset values
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      st_q           <= '0;
      st_q.in_fn[0]  <= RST_IN1_FN;
      st_q.in_fn[1]  <= RST_IN2_FN;
      st_q.in_fn[2]  <= RST_IN3_FN;
      st_q.in_fn[3]  <= RST_IN4_FN;
      st_q.in_fn[4]  <= RST_IN5_FN;
      st_q.in_fn2[0] <= RST_IN2_FN2;
      st_q.in_fn2[1] <= RST_IN3_FN2;

      st_q.rly_a_fn  <= RST_RLY_A_FN;
      st_q.rly_b_fn  <= RST_RLY_B_FN;
      st_q.rel_cur   <= RST_REL_CUR;
      st_q.rel_freq  <= RST_REL_FREQ;
      st_q.rel_timer <= RST_REL_TIMER;
      st_q.eng_freq  <= RST_ENG_FREQ;
      st_q.eng_timer <= RST_ENG_TIMER;

      // Safe state
      st_q.brake     <= BRK_ENGAGED;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Gate drive dropped in the same cycle a channel opens
  // immediate gate cutoff
  assign o_gate_enable = chans_ok && !st_q.sto_trip;

  // Registered outputs
  assign o_reg_rdata              = st_q.rdata;
  assign o_reg_rvalid             = st_q.rvalid;

  assign o_relay_out_a            = st_q.rly_a;
  assign o_relay_out_b_changeover = st_q.rly_b;
  assign o_brake_relay_one        = brake_sig;
  assign o_brake_relay_two        = brake_sig;

  assign o_fault_output           = st_q.fault;
  assign o_sto_tripped            = st_q.sto_trip;

  assign o_forward_run            = st_q.forward_run;
  assign o_backward_run           = st_q.backward_run;
  assign o_target_zero            = !(st_q.forward_run || st_q.backward_run);
  assign o_freq_sel               = st_q.fsel;
  assign o_ramp_sel               = st_q.rsel;

endmodule // dtbl_terminal

// file: dtbl_checker.sv
// Port-level assertions of the terminal and brake logic
module dtbl_checker (
  input wire logic i_clk_sys,              // Clock
  input wire logic i_rst_b,                // Reset, low
  input wire logic i_safe_torque_cutoff_a, // Channel A
  input wire logic i_safe_torque_cutoff_b, // Channel B
  input wire logic i_reg_rd,               // Read strobe
  input wire logic o_reg_rvalid,           // Read valid
  input wire logic o_gate_enable,          // Gate drive
  input wire logic o_sto_tripped,          // Trip latch
  input wire logic o_fault_output,         // Fault latch
  input wire logic o_forward_run,          // Forward
  input wire logic o_backward_run,         // Backward
  input wire logic o_target_zero,          // Ramp to zero
  input wire logic o_brake_relay_one,      // Brake relay one
  input wire logic o_brake_relay_two       // Brake relay two
);
  timeunit 1ns / 100ps;
  default clocking dcb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  logic run;   // Either direction
  logic chans; // Both channels closed
  assign run = o_forward_run || o_backward_run;
  assign chans = i_safe_torque_cutoff_a && i_safe_torque_cutoff_b;
  a_gate_follows_chans: assert property (o_gate_enable == (chans && !o_sto_tripped))
    else $error("gate enable wrong");
  a_open_sets_trip: assert property (!chans |=> o_sto_tripped)
    else $error("trip not latched");
  a_trip_blocks_run: assert property (o_sto_tripped [*2] |-> !run)
    else $error("run during trip");
  a_trip_holds_fault: assert property (o_sto_tripped |-> o_fault_output)
    else $error("fault clear during trip");
  a_brake_relays_pair: assert property (o_brake_relay_one == o_brake_relay_two)
    else $error("brake relays differ");
  a_one_direction: assert property (!(o_forward_run && o_backward_run))
    else $error("both directions");
  a_zero_when_idle: assert property (o_target_zero == !run)
    else $error("zero target wrong");
  a_release_needs_run: assert property (
    $rose(o_brake_relay_one) |-> $past(run) || $past(run, 2) || $past(run, 3))
    else $error("release without run");
  a_engage_needs_stop: assert property (
    $fell(o_brake_relay_one) |-> !$past(run) || !$past(run, 2) || !$past(run, 3))
    else $error("engage without stop");
  a_read_answers: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  c_release: cover property ($rose(o_brake_relay_one));
  c_trip: cover property ($rose(o_sto_tripped));
  c_read: cover property (i_reg_rd ##1 o_reg_rvalid);
endmodule // dtbl_checker

bind dtbl_terminal dtbl_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_safe_torque_cutoff_a(i_safe_torque_cutoff_a),
  .i_safe_torque_cutoff_b(i_safe_torque_cutoff_b),
  .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid), .o_gate_enable(o_gate_enable),
  .o_sto_tripped(o_sto_tripped), .o_fault_output(o_fault_output),
  .o_forward_run(o_forward_run), .o_backward_run(o_backward_run),
  .o_target_zero(o_target_zero), .o_brake_relay_one(o_brake_relay_one),
  .o_brake_relay_two(o_brake_relay_two)
);

// file: dtbl_partner.sv
// Model of the external brake and the controller's relay mask
module dtbl_partner #(
  parameter int unsigned MASK = 300_000_000 // Masked cycles after power-on
)(
  input  wire logic i_clk_sys,         // System clock
  input  wire logic i_brake_relay_one, // Brake relay one
  input  wire logic i_brake_relay_two, // Brake relay two
  output logic      o_brake_open,      // Brake mechanically open
  output logic      o_relays_valid     // Relay states trusted
);
  timeunit 1ns / 100ps;
  int unsigned cnt = 0; // Cycles since power-on
  always @(posedge i_clk_sys)
  begin
    if (cnt < MASK)
      cnt <= cnt + 1;
  end
  assign o_relays_valid = (cnt >= MASK);
  assign o_brake_open = o_relays_valid && i_brake_relay_one && i_brake_relay_two;
endmodule // dtbl_partner

// file: test_drive_terminal_brake_logic.sv
// Self-checking bench of the terminal and brake logic
module test_drive_terminal_brake_logic
  import dtbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;                   // System clock
  logic        rst_b, wr_s, rd_s, cut_a, cut_b, flt; // Controls
  logic [4:0]  din;                          // Inputs one to five
  logic [15:0] addr, wdata, rdata, freq, cur; // Bus and measurements
  logic        rvalid, rly_a, rly_b, brk1, brk2, fault, gate; // Outputs
  logic        trip, forward_run, backward_run, zero, brk_open, valid; // Outputs
  logic [1:0]  fsel, rsel;                   // Selects
  int          compares = 0;                 // Comparisons made
  int          n_mismatch = 0;               // Mismatches seen
  always #2.5 clk = ~clk;
  dtbl_terminal #(.TICK(4), .RST_HOLD(5)) uut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_input_one(din[0]), .i_input_two(din[1]), .i_input_three(din[2]),
    .i_input_four(din[3]), .i_input_five(din[4]), .i_safe_torque_cutoff_a(cut_a),
    .i_safe_torque_cutoff_b(cut_b), .i_fault_present(flt), .i_out_freq(freq),
    .i_out_current(cur), .o_relay_out_a(rly_a), .o_relay_out_b_changeover(rly_b),
    .o_brake_relay_one(brk1), .o_brake_relay_two(brk2), .o_fault_output(fault),
    .o_gate_enable(gate), .o_sto_tripped(trip), .o_forward_run(forward_run),
    .o_backward_run(backward_run), .o_target_zero(zero), .o_freq_sel(fsel), .o_ramp_sel(rsel));
  dtbl_partner #(.MASK(32)) u_far (.i_clk_sys(clk), .i_brake_relay_one(brk1),
    .i_brake_relay_two(brk2), .o_brake_open(brk_open), .o_relays_valid(valid));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    addr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    chk(16'(rvalid), 16'h0001);
    chk(rdata, e);
    cyc(1);
  endtask
  // Count cycles until brake relay one reaches a state
  task automatic wait_brk(input logic e, input int lo, input int hi);
    int n;
    n = 0;
    while (brk1 !== e && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask
  task automatic t_regs;
    rd(16'h0106, 16'h0039);
    rd(16'h0107, 16'h0063);
    rd(16'h010E, 16'h0064);
    rd(16'h0112, 16'h000A);
    rd(16'h0200, 16'h0000);
    wr(16'h010F, 16'h0300);
    rd(16'h010F, 16'h00FA);
    wr(16'h0110, 16'h0040);
    rd(16'h0110, 16'h0032);
    wr(16'h010E, 16'h0100);
    rd(16'h010E, 16'h00C8);
    $display("test regs done");
  endtask
  task automatic t_relay;
    chk(16'({rly_a, rly_b}), 16'h0000);
    flt = 1'b1;
    cyc(3);
    chk(16'({rly_b, fault}), 16'h0003);
    wr(16'h0107, 16'h044B);
    cyc(2);
    chk(16'(rly_b), 16'h0000);
    wr(16'h0106, 16'h0421);
    cyc(2);
    chk(16'(rly_a), 16'h0001);
    wr(16'h0106, 16'h0039);
    wr(16'h0107, 16'h0063);
    flt = 1'b0;
    din[4] = 1'b1;
    cyc(2);
    din[4] = 1'b0;
    cyc(3);
    chk(16'(fault), 16'h0001);
    din[4] = 1'b1;
    cyc(10);
    din[4] = 1'b0;
    cyc(3);
    chk(16'({fault, rly_b}), 16'h0000);
    $display("test relay done");
  endtask
  task automatic t_dir;
    for (int i = 0; i < 16; i++)
    begin
      din[3:0] = i[3:0];
      cyc(2);
      chk(16'({forward_run, backward_run, zero}), 16'({i[0] & !i[3], i[3] & !i[0], i[0] == i[3]}));
      chk(16'(rsel), 16'(i[2:1]));
      if (i[0] != i[3])
        chk(16'(fsel), 16'(i[2:1]));
    end
    din[3:0] = 4'h0;
    wr(16'h0102, 16'h03E8);
    chk(16'(fsel), 16'h0001);
    wr(16'h0102, 16'h0000);
    $display("test direction done");
  endtask
  task automatic t_brake;
    wr(16'h010E, 16'h0064);
    wr(16'h0110, 16'h0003);
    wr(16'h0112, 16'h0002);
    cur = 16'h00C8;
    din[0] = 1'b1;
    wait_brk(1'b1, 11, 18);
    cyc(2);
    chk(16'({rly_a, brk_open, valid}), 16'h0007);
    din[0] = 1'b0;
    cur = 16'h0000;
    freq = 16'h0014;
    cyc(4);
    freq = 16'h0000;
    cyc(4);
    freq = 16'h0014;
    cyc(1);
    freq = 16'h0000;
    wait_brk(1'b0, 7, 14);
    $display("test brake done");
  endtask
  task automatic t_sto;
    cut_a = 1'b0;
    #1;
    chk(16'(gate), 16'h0000);
    cyc(2);
    chk(16'({trip, fault}), 16'h0003);
    cut_a = 1'b1;
    din[0] = 1'b1;
    cyc(3);
    chk(16'({forward_run, gate}), 16'h0000);
    din[4] = 1'b1;
    cyc(10);
    din[4] = 1'b0;
    cyc(4);
    chk(16'({trip, fault, forward_run, gate}), 16'h0003);
    rd(16'h0130, 16'h0028);
    $display("test cutoff done");
  endtask
  task automatic conclude;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {rst_b, wr_s, rd_s, flt, din, addr, wdata, freq, cur} = '0;
    {cut_a, cut_b} = 2'b11;
    cyc(16);
    rst_b = 1'b1;
    cyc(1);
    t_regs;
    t_relay;
    t_dir;
    t_brake;
    t_sto;
    conclude;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    conclude;
  end
endmodule // test_drive_terminal_brake_logic
